/* File: inc/tse_pkg.sv */
// shared constants, carriers and state layout for toner supply supervision
package tse_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DENS_REF = 8'h08;
    localparam logic [7:0] ADDR_FIXED_ON = 8'h0c;
    localparam logic [7:0] ADDR_GAIN = 8'h10;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h14;
    localparam logic [7:0] ADDR_INT_MASK = 8'h18;
    localparam logic [7:0] ADDR_PATCH_READ = 8'h1c;
    localparam logic [7:0] ADDR_PATCH_TARGET = 8'h20;
    // control field positions
    localparam int CTRL_PATCH_FAULT = 0;
    localparam int CTRL_DENS_FAULT = 1;
    localparam int CTRL_SKIP = 2;
    // interrupt bit positions
    localparam int INT_NEAR = 0;
    localparam int INT_END = 1;
    localparam int INT_STOP = 2;
    localparam int INT_PATCH = 3;
    localparam int INT_REC = 4;
    localparam int INT_W = 5;
    // reset values
    localparam logic [7:0] DENS_REF_RST = 8'h80;
    localparam logic [15:0] FIXED_ON_RST = 16'h0100;
    localparam logic [3:0] GAIN_RST = 4'h2;
    localparam logic [3:0] REC_ALL = 4'hf;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned SAMPLE_GAP_NS = 4000000;
    localparam int unsigned SAMPLE_GAP_CYC = SAMPLE_GAP_NS / CLK_PERIOD_NS;
    localparam logic [15:0] REC_CYCLES = 16'h0400;
    // counts
    localparam logic [7:0] WINDOW_SAMPLES = 8'ha0;
    localparam logic [7:0] ABSENT_LIMIT = 8'h14;
    localparam logic [1:0] ABSENT_RUN = 2'h3;
    localparam logic [3:0] SHEETS_AFTER_NEAR = 4'ha;
    localparam logic [3:0] COPIES_PER_PATCH = 4'ha;
    localparam logic [31:0] SHEET_PIXELS_DEF = 32'h00100000;
    localparam logic [31:0] END_SHEETS = 32'h0000000a;
    localparam int PIX_SHIFT = 8;
    // patch mass targets in units of 0.01 mg/cm2
    localparam logic [7:0] TARGET_CHROMA = 8'h46;
    localparam logic [7:0] TARGET_BLACK = 8'h1e;
    localparam logic [1:0] COLOR_BLACK = 2'h0;

    typedef enum logic [1:0] {
        TSE_MODE_COMBINED,
        TSE_MODE_PROP,
        TSE_MODE_FIXED
    } tse_mode_t;

    // toner-end sensor and development position
    typedef struct packed {
        logic toner_level;
        logic develop_pos;
        logic [1:0] develop_color;
    } tse_sense_t;

    // pixel counter report
    typedef struct packed {
        logic valid;
        logic [1:0] color;
        logic [15:0] count;
    } tse_pixel_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic patch_fault;
        logic dens_fault;
        logic [7:0] dens_ref;
        logic [15:0] fixed_on;
        logic [3:0] gain;
        logic [INT_W-1:0] int_status;
        logic [INT_W-1:0] int_mask;
        logic [16:0] tick;
        logic [7:0] samples;
        logic [7:0] lows;
        logic [1:0] win_color;
        logic win_active;
        logic win_hold;
        logic [3:0][1:0] absent_run;
        logic [3:0] near;
        logic [3:0] tend;
        logic [3:0][3:0] sheets;
        logic [3:0][31:0] end_pix;
        logic [3:0][15:0] pix_since;
        logic [3:0] copies;
        logic [3:0] patch_pending;
        logic [3:0][7:0] patch_read;
        logic patch_expose;
        logic patch_wait;
        logic [1:0] patch_color;
        logic [3:0] clutch;
        logic [15:0] clutch_cnt;
        logic [1:0] clutch_color;
        logic copy_stop;
        logic door_q;
        logic swap_seen;
        logic [1:0] xchg_color;
        logic xchg_req;
        logic [3:0] rec_pending;
        logic [1:0] rec_color;
        logic rec_active;
        logic [15:0] rec_cnt;
    } tse_state_t;
endpackage

/* File: rtl/tse_top.sv */
// toner supply control, near-end and end detection, and recovery
// Function
// - default supply mode combines density sensor, patch sensor, pixels
// - patch sensor faulty: supply from density sensor reading only
// - both sensors faulty: fixed, constant supply amount
// - supply amount is only the clutch on time
// - default mode uses density reading plus accumulated pixel count
// - expose patch in image gaps at standard power, capture its reading
// - patch cycle repeats once every ten copies
// - patch target 0.7 mg/cm2 for chromatic colours, 0.3 for black
// - toner-end sensor is binary: high present, low absent
// - per colour window takes 160 samples spaced 4 ms apart
// - window is toner-absent only with more than 20 low samples
// - three consecutive absent windows raise near-end and its indicator
// - after near-end, toner end once pixels reach ten full sheets
// - after near-end stop at later of tenth sheet or toner end
// - door close moves next colour awaiting replacement to exchange
// - replaced cartridge with door closed starts recovery for it
// - second colour follows if door reopens or operator skips first
// - at power-up every colour is treated as replaced and recovered
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module tse_top
    import tse_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = SAMPLE_GAP_CYC,
    parameter logic [31:0] SHEET_PIXELS = SHEET_PIXELS_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire tse_sense_t sense,
    input wire logic [7:0] density_val,
    input wire logic [7:0] patch_val,
    input wire logic patch_valid,
    input wire logic image_gap,
    input wire logic [1:0] gap_color,
    input wire logic sheet_done,
    input wire tse_pixel_t pixel,
    input wire logic supply_req,
    input wire logic [1:0] supply_color,
    input wire logic door_open,
    input wire logic cartridge_swap,
    input wire logic skip_color,
    output logic [3:0] supply_clutch,
    output logic patch_expose,
    output logic [1:0] patch_color,
    output logic [3:0] near_end_led,
    output logic copy_stop,
    output logic exchange_req,
    output logic [1:0] exchange_color,
    output logic recovery_active,
    output logic [1:0] recovery_color
);
    localparam logic [31:0] END_PIXELS = 32'(END_SHEETS * SHEET_PIXELS);

    // patch mass target per colour
    function automatic logic [7:0] target_of(input logic [1:0] c);
        return (c == COLOR_BLACK) ? TARGET_BLACK : TARGET_CHROMA;
    endfunction

    // supply mode from the sensor fault flags
    function automatic tse_mode_t mode_of(input logic pf, input logic df);
        if (pf && df) begin
            return TSE_MODE_FIXED;
        end else if (pf) begin
            return TSE_MODE_PROP;
        end
        return TSE_MODE_COMBINED;
    endfunction

    // lowest set colour of a mask
    function automatic logic [1:0] first_set(input logic [3:0] m);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (m[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    tse_state_t st;
    tse_state_t next_st;
    tse_mode_t mode;
    logic [7:0] err;
    logic [7:0] pdiff;
    logic [15:0] prop_on;
    logic [15:0] pix_term;
    logic [17:0] comb_sum;
    logic [15:0] on_time;
    logic bus_rd;
    logic bus_wr;
    logic win_done;
    logic [7:0] lows_fin;
    logic [INT_W-1:0] int_set;
    logic [3:0] awaiting;

    // supply amount for the requested colour
    always_comb begin
        mode = mode_of(st.patch_fault, st.dens_fault);
        err = (st.dens_ref > density_val) ? st.dens_ref - density_val : 8'h00;
        pdiff = (target_of(supply_color) > st.patch_read[supply_color]) ?
            target_of(supply_color) - st.patch_read[supply_color] : 8'h00;
        prop_on = {8'h00, err} * {12'h000, st.gain};
        pix_term = st.pix_since[supply_color] >> PIX_SHIFT;
        comb_sum = {2'h0, prop_on} + {2'h0, pix_term} + {10'h000, pdiff};
        unique case (mode)
            TSE_MODE_FIXED: on_time = st.fixed_on;
            TSE_MODE_PROP: on_time = prop_on;
            default: on_time = (comb_sum[17:16] != 2'h0) ? 16'hffff :
                comb_sum[15:0];
        endcase
    end

    // next state
    always_comb begin
        next_st = st;
        int_set = '0;
        bus_rd = psel && penable && !st.pready;
        bus_wr = psel && penable && st.pready && pwrite;
        win_done = 1'b0;
        lows_fin = st.lows;

        // apb slave: answer one cycle into access, write at completing edge
        next_st.pready = bus_rd;
        if (bus_rd) begin
            next_st.pslverr = 1'b0;
            unique case (paddr)
                ADDR_CTRL: next_st.prdata = {30'h0, st.dens_fault,
                    st.patch_fault};
                ADDR_STATUS: next_st.prdata = {6'h00, st.rec_pending,
                    st.rec_active, st.rec_color, st.copy_stop, st.tend,
                    st.near, 8'h00, mode};
                ADDR_DENS_REF: next_st.prdata = {24'h0, st.dens_ref};
                ADDR_FIXED_ON: next_st.prdata = {16'h0, st.fixed_on};
                ADDR_GAIN: next_st.prdata = {28'h0, st.gain};
                ADDR_INT_STATUS: next_st.prdata = {27'h0, st.int_status};
                ADDR_INT_MASK: next_st.prdata = {27'h0, st.int_mask};
                ADDR_PATCH_READ: next_st.prdata = st.patch_read;
                ADDR_PATCH_TARGET: next_st.prdata = {target_of(2'h3),
                    target_of(2'h2), target_of(2'h1), target_of(2'h0)};
                default: begin
                    next_st.prdata = 32'h0;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end else if (!(psel && penable)) begin
            next_st.pslverr = 1'b0;
        end
        if (bus_wr) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    next_st.patch_fault = pwdata[CTRL_PATCH_FAULT];
                    next_st.dens_fault = pwdata[CTRL_DENS_FAULT];
                end
                ADDR_DENS_REF: next_st.dens_ref = pwdata[7:0];
                ADDR_FIXED_ON: next_st.fixed_on = pwdata[15:0];
                ADDR_GAIN: next_st.gain = pwdata[3:0];
                ADDR_INT_MASK: next_st.int_mask = pwdata[INT_W-1:0];
                default: ;
            endcase
        end

        // clutch timing: on time is the whole supply amount
        if (st.clutch_cnt != 16'h0) begin
            next_st.clutch_cnt = st.clutch_cnt - 16'h1;
        end
        if (supply_req && st.clutch_cnt == 16'h0) begin
            next_st.clutch_cnt = on_time;
            next_st.clutch_color = supply_color;
            next_st.pix_since[supply_color] = 16'h0;
        end
        next_st.clutch = '0;
        if (next_st.clutch_cnt != 16'h0) begin
            next_st.clutch[next_st.clutch_color] = 1'b1;
        end

        // pixel accumulation for supply and for the end condition
        if (pixel.valid) begin
            next_st.pix_since[pixel.color] =
                (st.pix_since[pixel.color] > 16'hffff - pixel.count) ?
                16'hffff : st.pix_since[pixel.color] + pixel.count;
            if (st.near[pixel.color] && !st.tend[pixel.color]) begin
                next_st.end_pix[pixel.color] = st.end_pix[pixel.color] +
                    {16'h0, pixel.count};
                if (next_st.end_pix[pixel.color] >= END_PIXELS) begin
                    next_st.tend[pixel.color] = 1'b1;
                    int_set[INT_END] = 1'b1;
                end
            end
        end

        // patch exposure first, so a fresh schedule wins over a consumed one
        next_st.patch_expose = 1'b0;
        if (image_gap && st.patch_pending[gap_color] && !st.patch_wait) begin
            next_st.patch_expose = 1'b1;
            next_st.patch_color = gap_color;
            next_st.patch_wait = 1'b1;
            next_st.patch_pending[gap_color] = 1'b0;
        end

        // patch scheduling every ten copies
        if (sheet_done) begin
            if (st.copies == COPIES_PER_PATCH - 4'h1) begin
                next_st.copies = 4'h0;
                next_st.patch_pending = 4'hf;
            end else begin
                next_st.copies = st.copies + 4'h1;
            end
            for (int c = 0; c < 4; c++) begin
                if (st.near[c] && st.sheets[c] != SHEETS_AFTER_NEAR) begin
                    next_st.sheets[c] = st.sheets[c] + 4'h1;
                end
            end
        end
        if (patch_valid && st.patch_wait) begin
            next_st.patch_read[st.patch_color] = patch_val;
            next_st.patch_wait = 1'b0;
            int_set[INT_PATCH] = 1'b1;
        end

        // toner-end sensor windows
        if (!sense.develop_pos) begin
            next_st.win_active = 1'b0;
            next_st.win_hold = 1'b0;
        end else if (!st.win_active && !st.win_hold) begin
            next_st.win_active = 1'b1;
            next_st.win_color = sense.develop_color;
            next_st.tick = 17'h0;
            next_st.samples = 8'h0;
            next_st.lows = 8'h0;
        end else if (st.win_active) begin
            if (st.tick == 17'(SAMPLE_CYC - 1)) begin
                next_st.tick = 17'h0;
                next_st.samples = st.samples + 8'h1;
                lows_fin = st.lows + {7'h0, !sense.toner_level};
                next_st.lows = lows_fin;
                if (next_st.samples == WINDOW_SAMPLES) begin
                    win_done = 1'b1;
                    next_st.win_active = 1'b0;
                    next_st.win_hold = 1'b1;
                end
            end else begin
                next_st.tick = st.tick + 17'h1;
            end
        end
        if (win_done) begin
            if (lows_fin > ABSENT_LIMIT) begin
                if (st.absent_run[st.win_color] != ABSENT_RUN) begin
                    next_st.absent_run[st.win_color] =
                        st.absent_run[st.win_color] + 2'h1;
                end
                if (st.absent_run[st.win_color] == ABSENT_RUN - 2'h1 &&
                    !st.near[st.win_color]) begin
                    next_st.near[st.win_color] = 1'b1;
                    int_set[INT_NEAR] = 1'b1;
                end
            end else begin
                next_st.absent_run[st.win_color] = 2'h0;
            end
        end

        // cartridge exchange on door close
        next_st.door_q = door_open;
        next_st.xchg_req = 1'b0;
        if (door_open && cartridge_swap) begin
            next_st.swap_seen = 1'b1;
        end
        if (st.door_q && !door_open) begin
            if (st.swap_seen) begin
                next_st.rec_pending[st.xchg_color] = 1'b1;
                next_st.swap_seen = 1'b0;
            end
            awaiting = st.tend & ~next_st.rec_pending;
            if (awaiting != 4'h0) begin
                next_st.xchg_req = 1'b1;
                next_st.xchg_color = first_set(awaiting);
            end
        end else begin
            awaiting = 4'h0;
        end

        // recovery sequencing, one colour at a time
        if (st.rec_active) begin
            if ((door_open && !st.door_q) || skip_color ||
                (bus_wr && paddr == ADDR_CTRL && pwdata[CTRL_SKIP])) begin
                next_st.rec_active = 1'b0;
                next_st.rec_pending[st.rec_color] = 1'b0;
            end else if (st.rec_cnt == REC_CYCLES - 16'h1) begin
                next_st.rec_active = 1'b0;
                next_st.rec_pending[st.rec_color] = 1'b0;
                next_st.near[st.rec_color] = 1'b0;
                next_st.tend[st.rec_color] = 1'b0;
                next_st.sheets[st.rec_color] = 4'h0;
                next_st.end_pix[st.rec_color] = 32'h0;
                next_st.absent_run[st.rec_color] = 2'h0;
                int_set[INT_REC] = 1'b1;
            end else begin
                next_st.rec_cnt = st.rec_cnt + 16'h1;
            end
        end else if (st.rec_pending != 4'h0 && !door_open) begin
            next_st.rec_active = 1'b1;
            next_st.rec_color = first_set(st.rec_pending);
            next_st.rec_cnt = 16'h0;
        end

        // stop copying at the later of tenth sheet and toner end
        // taken after recovery so a cleared colour never holds the stop
        next_st.copy_stop = 1'b0;
        for (int c = 0; c < 4; c++) begin
            if (next_st.near[c] && next_st.tend[c] &&
                next_st.sheets[c] == SHEETS_AFTER_NEAR) begin
                next_st.copy_stop = 1'b1;
            end
        end
        int_set[INT_STOP] = next_st.copy_stop && !st.copy_stop;

        // sticky interrupts, set wins over write-one clear
        next_st.int_status = st.int_status;
        if (bus_wr && paddr == ADDR_INT_STATUS) begin
            next_st.int_status = st.int_status & ~pwdata[INT_W-1:0];
        end
        next_st.int_status = next_st.int_status | int_set;
        next_st.irq = |(next_st.int_status & next_st.int_mask);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.dens_ref <= DENS_REF_RST;
            st.fixed_on <= FIXED_ON_RST;
            st.gain <= GAIN_RST;
            st.rec_pending <= REC_ALL;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign irq = st.irq;
    assign supply_clutch = st.clutch;
    assign patch_expose = st.patch_expose;
    assign patch_color = st.patch_color;
    assign near_end_led = st.near;
    assign copy_stop = st.copy_stop;
    assign exchange_req = st.xchg_req;
    assign exchange_color = st.xchg_color;
    assign recovery_active = st.rec_active;
    assign recovery_color = st.rec_color;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    mode_fixed_a: assert property (supply_req && st.clutch_cnt == 16'h0 &&
        st.patch_fault && st.dens_fault |=> st.clutch_cnt == $past(st.fixed_on))
        else $error("fixed mode on time wrong");
    mode_prop_a: assert property (supply_req && st.clutch_cnt == 16'h0 &&
        st.patch_fault && !st.dens_fault |=>
        st.clutch_cnt == $past(prop_on))
        else $error("proportional on time wrong");
    mode_comb_a: assert property (supply_req && st.clutch_cnt == 16'h0 &&
        !st.patch_fault |=> st.clutch_cnt >= $past(pix_term))
        else $error("combined on time ignores pixels");
    clutch_len_a: assert property ($rose(|supply_clutch) |->
        st.clutch_cnt == $past(on_time))
        else $error("clutch on without load");
    patch_gap_a: assert property (patch_expose |-> $past(image_gap))
        else $error("patch outside image gap");
    patch_every_a: assert property (sheet_done && st.copies == 4'h9 |=>
        st.patch_pending == 4'hf)
        else $error("patch not scheduled at tenth copy");
    absent_edge_a: assert property (win_done && lows_fin == ABSENT_LIMIT |=>
        st.absent_run[$past(st.win_color)] == 2'h0)
        else $error("twenty lows counted as absent");
    near_led_a: assert property ($rose(near_end_led[1]) |->
        $past(st.absent_run[1]) == 2'h2 && st.absent_run[1] == 2'h3)
        else $error("near end without three windows");
    stop_cond_a: assert property (copy_stop |-> |(st.near & st.tend))
        else $error("copy stop without toner end");
    exch_door_a: assert property (exchange_req |-> $past(st.door_q) &&
        !$past(door_open))
        else $error("exchange without door close");

    near_seen_c: cover property ($rose(|near_end_led));
    stop_seen_c: cover property ($rose(copy_stop));
    rec_done_c: cover property ($fell(recovery_active) ##1 recovery_active);
    patch_cap_c: cover property (patch_expose ##[1:20] patch_valid);
endmodule // tse_top

/* File: tb/tse_sensor_model.sv */
// toner-end sensor and development position model
`timescale 1ns/1ns
module tse_sensor_model
    import tse_pkg::*;
(
    input wire logic pclk,
    output tse_sense_t sense
);
    // sensor idles high, no colour at development position
    initial sense = '{1'b1, 1'b0, 2'h0};
    // one development pass; any 4*n low cycles hold exactly n samples
    task automatic window(input logic [1:0] c, input int n);
        @(posedge pclk);
        sense <= '{1'b1, 1'b1, c};
        repeat (100) @(posedge pclk);
        sense.toner_level <= 1'b0;
        repeat (4 * n) @(posedge pclk);
        sense.toner_level <= 1'b1;
        repeat (600 - 4 * n) @(posedge pclk);
        sense.develop_pos <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
endmodule // tse_sensor_model

/* File: tb/test_toner_supply_end_detect.sv */
// self-checking bench for toner supply supervision
`timescale 1ns/1ns
module test_toner_supply_end_detect;
    import tse_pkg::*;
    localparam logic [31:0] SP = 32'h10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic patch_valid, image_gap, sheet_done, supply_req, door_open;
    logic cartridge_swap, skip_color, patch_expose, copy_stop;
    logic exchange_req, recovery_active;
    logic [7:0] paddr, density_val, patch_val;
    logic [31:0] pwdata, prdata, rv, seed = 32'h43c0;
    logic [1:0] gap_color, supply_color, patch_color, exchange_color;
    logic [1:0] recovery_color, rc;
    logic [3:0] supply_clutch, near_end_led;
    logic [64:0] e;
    logic [64:0] expq[$];
    tse_sense_t sense;
    tse_pixel_t pixel;
    int n_mismatch = 0, checks_done = 0, i;
    int lows[5] = '{20, 19, 21, 25, 21};
    tse_top #(.SAMPLE_CYC(4), .SHEET_PIXELS(SP)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .sense(sense),
        .density_val(density_val), .patch_val(patch_val),
        .patch_valid(patch_valid), .image_gap(image_gap),
        .gap_color(gap_color), .sheet_done(sheet_done), .pixel(pixel),
        .supply_req(supply_req), .supply_color(supply_color),
        .door_open(door_open), .cartridge_swap(cartridge_swap),
        .skip_color(skip_color), .supply_clutch(supply_clutch),
        .patch_expose(patch_expose), .patch_color(patch_color),
        .near_end_led(near_end_led), .copy_stop(copy_stop),
        .exchange_req(exchange_req), .exchange_color(exchange_color),
        .recovery_active(recovery_active), .recovery_color(recovery_color));
    tse_sensor_model model_u (.pclk(pclk), .sense(sense));
    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, logic [31:0] m, x, logic r = 0);
        expq.push_back({r, m, x});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic supply(input logic [1:0] c, input int x);
        int n;
        n = 0;
        @(posedge pclk);
        {supply_req, supply_color} <= {1'b1, c};
        @(posedge pclk);
        supply_req <= 1'b0;
        repeat (300) begin
            #1;
            if (supply_clutch[c] === 1'b1) n++;
            @(posedge pclk);
        end
        check("clutch on time", 32'(n), 32'(x));
    endtask
    task automatic pix(input logic [15:0] n);
        @(posedge pclk);
        pixel <= '{1'b1, 2'h1, n};
        @(posedge pclk);
        pixel.valid <= 1'b0;
    endtask
    // read results taken off the queue as they appear
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = expq.pop_front();
            check("prdata", prdata & e[63:32], e[31:0]);
            check("pslverr", 32'(pslverr), 32'(e[64]));
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (30000) @(posedge pclk);
        n_mismatch++;
        conclude();
    end
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {patch_valid, image_gap, sheet_done, supply_req, door_open} = '0;
        {cartridge_swap, skip_color, gap_color, supply_color} = '0;
        {density_val, patch_val, pixel} = {8'h7c, 8'h0, 19'h0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1 check("rec", 32'(recovery_active), 32'h1);
        @(posedge pclk);
        skip_color <= 1'b1;
        @(posedge pclk);
        skip_color <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 check("next", 32'(recovery_color), 32'h1);
        repeat (4200) @(posedge pclk);
        rd(ADDR_INT_STATUS, 32'h1 << INT_REC, 32'h1 << INT_REC);
        rd(ADDR_STATUS, 32'h3, 32'(TSE_MODE_COMBINED));
        rd(ADDR_PATCH_TARGET, '1, {{3{TARGET_CHROMA}}, TARGET_BLACK});
        rd(8'hfc, '1, 32'h0, 1'b1);
        supply(2'h3, 78);
        apb(1'b1, ADDR_CTRL, 32'h1);
        rd(ADDR_STATUS, 32'h3, 32'(TSE_MODE_PROP));
        supply(2'h3, 8);
        apb(1'b1, ADDR_FIXED_ON, 32'h5);
        apb(1'b1, ADDR_CTRL, 32'h3);
        rd(ADDR_STATUS, 32'h3, 32'(TSE_MODE_FIXED));
        supply(2'h3, 5);
        apb(1'b1, ADDR_CTRL, 32'h0);
        for (i = 0; i < 5; i++) begin
            model_u.window(2'h1, lows[i]);
            if (i == 3) rd(ADDR_STATUS, 32'h800, 32'h0);
        end
        rd(ADDR_STATUS, 32'h800, 32'h800);
        #1 check("led", 32'(near_end_led), 32'h2);
        check("irq masked", 32'(irq), 32'h0);
        apb(1'b1, ADDR_INT_MASK, 32'h1);
        rd(ADDR_INT_STATUS, 32'h1, 32'h1);
        #1 check("irq", 32'(irq), 32'h1);
        apb(1'b1, ADDR_INT_STATUS, 32'h1);
        rd(ADDR_INT_STATUS, 32'h1, 32'h0);
        #1 check("irq clear", 32'(irq), 32'h0);
        pix(16'(10 * SP - 1));
        rd(ADDR_STATUS, 32'h8000, 32'h0);
        pix(16'h1);
        rd(ADDR_STATUS, 32'h8000, 32'h8000);
        for (i = 1; i <= 10; i++) begin
            @(posedge pclk);
            sheet_done <= 1'b1;
            @(posedge pclk);
            sheet_done <= 1'b0;
            if (i == 9) rd(ADDR_STATUS, 32'h40000, 32'h0);
        end
        rd(ADDR_STATUS, 32'h40000, 32'h40000);
        #1 check("stop pin", 32'(copy_stop), 32'h1);
        @(posedge pclk);
        {image_gap, gap_color} <= 3'b110;
        @(posedge pclk);
        image_gap <= 1'b0;
        #1 check("patch", {29'h0, patch_expose, patch_color}, 32'h6);
        rv = rnd();
        @(posedge pclk);
        {patch_valid, patch_val} <= {1'b1, rv[7:0]};
        @(posedge pclk);
        patch_valid <= 1'b0;
        rd(ADDR_PATCH_READ, 32'hff0000, {8'h0, rv[7:0], 16'h0});
        @(posedge pclk);
        door_open <= 1'b1;
        @(posedge pclk);
        cartridge_swap <= 1'b1;
        @(posedge pclk);
        {cartridge_swap, door_open} <= 2'b00;
        #1;
        for (i = 0; i < 20 && exchange_req !== 1'b1; i++) #40;
        check("xchg", {30'h0, exchange_color}, 32'h1);
        for (i = 0; i < 20 && recovery_active !== 1'b1; i++) #40;
        check("rec", 32'(recovery_active), 32'h1);
        rc = recovery_color;
        @(posedge pclk);
        skip_color <= 1'b1;
        @(posedge pclk);
        skip_color <= 1'b0;
        repeat (3) @(posedge pclk);
        #1 check("skip", 32'(recovery_active && recovery_color == rc), 0);
        conclude();
    end
endmodule // test_toner_supply_end_detect
